// ### logic/hms_pkg.sv
/*
 * Package for the hidden memory supervisor: memory layout, register
 * defaults, update pattern and timing constants.
 * Assumes a single 200 MHz clock domain.
 */
package hms_pkg;
  // ***********************************************
  // Memory layout
  // ***********************************************
  localparam int          HMS_MEM_BYTES  = 2048;
  localparam int          HMS_AW         = 11;
  localparam logic [10:0] HMS_REG_BASE   = 11'h7f8;
  localparam logic [2:0]  HMS_IX_AC1     = 3'h0;
  localparam logic [2:0]  HMS_IX_OPENL   = 3'h4;
  localparam logic [2:0]  HMS_IX_OPENH   = 3'h5;
  localparam logic [2:0]  HMS_IX_CFG     = 3'h6;
  localparam logic [2:0]  HMS_IX_SCR     = 3'h7;
  localparam int          HMS_MATCHES    = 3;

  // ***********************************************
  // Register defaults and update pattern
  // ***********************************************
  localparam logic [7:0]  HMS_AC1_DEF    = 8'hc5;
  localparam logic [7:0]  HMS_AC2_DEF    = 8'ha6;
  localparam logic [7:0]  HMS_AC3_DEF    = 8'h39;
  localparam logic [7:0]  HMS_AC4_DEF    = 8'h2b;
  localparam logic [7:0]  HMS_OPENL_DEF  = 8'hff;
  localparam logic [7:0]  HMS_OPENH_DEF  = 8'h07;
  localparam logic [7:0]  HMS_CFG_DEF    = 8'h3a;
  localparam logic [7:0]  HMS_SCR_DEF    = 8'h1f;
  localparam logic [31:0] HMS_UPD_PAT    = 32'hd4c6593a;
  localparam logic [31:0] HMS_AC_DEF     = 32'h2b39a6c5;

  // Config byte fields
  localparam int          HMS_CFG_RSTEN  = 1;
  localparam int          HMS_CFG_LOWBLK = 2;
  localparam int          HMS_CFG_NOAUTO = 3;
  // Chosen fields of the status/control byte
  localparam int          HMS_SCR_WDSEL  = 0;
  localparam int          HMS_SCR_WDIRQ  = 2;
  localparam logic [1:0]  HMS_WD_OFF     = 2'h3;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int          HMS_CLK_MHZ    = 200;
  localparam int          HMS_TICK_NS    = 25000;
  localparam int          HMS_TICK_CYC   = HMS_TICK_NS * HMS_CLK_MHZ / 1000;
  localparam int          HMS_HOLD_MS    = 120;
  localparam int          HMS_RSTW_MS    = 150;
  localparam int          HMS_IRQW_US    = 100;
  localparam int          HMS_WD0_MS     = 125;
  localparam int          HMS_WD1_MS     = 500;
  localparam int          HMS_WD2_MS     = 2000;
  localparam int          HMS_TICKS_PER_MS = 1000000 / HMS_TICK_NS;
  localparam int          HMS_IRQW_TICKS = HMS_IRQW_US * 1000 / HMS_TICK_NS;
endpackage

// ### logic/hms_top.sv
/*
 * Hidden memory supervisor: 2K hidden SRAM opened and closed by address
 * matches, chip-select gating, reset and power-fail interrupt outputs,
 * watchdog. Comparator results arrive as digital pins; bus pins are
 * asynchronous and pass two flip-flops before use.
 */
// Overview of operation
// - 2K internal SRAM; top eight bytes are control and status.
// - Hidden window at upper or lower 2K of a 64K segment.
// - Three consecutive matches then chip enable high opens the memory.
// - Falling compare strobe latches the 16-bit address regardless of enable.
// - While open, gated select stays inactive inside the 2K window.
// - Same three-match sequence at the same address closes it.
// - Default open/close address is 07ff, reprogrammable.
// - Contents kept on close; config applied only with update pattern.
// - Without auto-open, power loss while open needs a close first.
// - Supply below trip level write-protects internal SRAM.
// - After power-up, memory stays inaccessible for the hold-off time.
// - Three bad samples on threshold input pulse both interrupt outputs.
// - Reset needs three samples; resets active while low, then pulse width.
// - Config bit selects trip level, also the write-protect level.
// - Config bit inhibits both reset outputs.
// - Host strobes watchdog within each period or a timeout occurs.
// - Completed open or close sequence restarts the watchdog.
// - Timeout 125 ms, 500 ms, 2 s or disabled; disabled by default.
// - Status/control bit routes watchdog timeout to the interrupt pair.
// - Supply failure restarts hold-off, forcing gated select inactive even mid-cycle.
// - Gated select held off after power-up, else follows chip enable.
// - Default-restore input resets registers and holds resets active.
// - Closing with update pattern restores the access control bytes.
`timescale 1ns/1ps
module hms_top
  import hms_pkg::*;
#(
  parameter int HOLD_TICKS = HMS_HOLD_MS * HMS_TICKS_PER_MS,
  parameter int RSTW_TICKS = HMS_RSTW_MS * HMS_TICKS_PER_MS,
  parameter int WD0_TICKS  = HMS_WD0_MS * HMS_TICKS_PER_MS,
  parameter int WD1_TICKS  = HMS_WD1_MS * HMS_TICKS_PER_MS,
  parameter int WD2_TICKS  = HMS_WD2_MS * HMS_TICKS_PER_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Host bus
  input  wire logic [15:0] addr_in,
  input  wire logic        addr_compare_strobe_n,
  input  wire logic        chip_en_n,
  input  wire logic        write_en_n,
  input  wire logic        out_en_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  // Supervisor pins
  input  wire logic        wdog_strobe_n,
  input  wire logic        default_restore_n,
  input  wire logic        threshold_sense_in,
  input  wire logic        trip_hi_sense_in,
  input  wire logic        trip_lo_sense_in,
  // Outputs
  output logic             gated_select_out,
  output logic             rst_out,
  output logic             rst_out_n,
  output logic             irq_out,
  output logic             irq_out_n,
  output logic             mem_open_out
);
  // ***********************************************
  // Input synchronisers
  // ***********************************************
  localparam int NS = 27;
  logic [NS-1:0] s1_q, s2_q;
  always_ff @(posedge clk) begin
    s1_q <= {addr_in, addr_compare_strobe_n, chip_en_n, write_en_n, out_en_n,
             wdog_strobe_n, default_restore_n, threshold_sense_in,
             trip_hi_sense_in, trip_lo_sense_in, 2'h0};
    s2_q <= s1_q;
  end
  logic [15:0] a_s;
  logic acs_s, ce_s, we_s, oe_s, wd_s, def_s, thr_s, thi_s, tlo_s;
  assign {a_s, acs_s, ce_s, we_s, oe_s, wd_s, def_s, thr_s, thi_s, tlo_s} = s2_q[NS-1:2];
  logic [7:0] d_s1_q, d_s_q;
  always_ff @(posedge clk) begin
    d_s1_q <= data_in;
    d_s_q  <= d_s1_q;
  end
  logic acs_d1_q, ce_d1_q, wd_d1_q;
  always_ff @(posedge clk) begin
    acs_d1_q <= acs_s;
    ce_d1_q  <= ce_s;
    wd_d1_q  <= wd_s;
  end
  logic acs_fall, ce_rise, wd_fall;
  assign acs_fall = acs_d1_q & ~acs_s;
  assign ce_rise  = ~ce_d1_q & ce_s;
  assign wd_fall  = wd_d1_q & ~wd_s;

  // ***********************************************
  // Sample tick and comparator qualification
  // ***********************************************
  // tick counter
  logic [15:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 16'(HMS_TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || tick) tick_cnt_q <= 16'h0;
    else tick_cnt_q <= tick_cnt_q + 16'h1;
  end
  logic [7:0] mem [HMS_MEM_BYTES];
  logic [7:0] cfg_act_q, scr_act_q;
  logic trip_raw;
  assign trip_raw = cfg_act_q[7] ? tlo_s : thi_s;
  logic [2:0] vlow_sh_q, thr_sh_q;
  logic       vlow_q, thr_q, thr_d1_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vlow_sh_q <= 3'h7;
      thr_sh_q  <= 3'h0;
      vlow_q    <= 1'b1;
      thr_q     <= 1'b0;
    end else if (tick) begin
      vlow_sh_q <= {vlow_sh_q[1:0], trip_raw};
      thr_sh_q  <= {thr_sh_q[1:0], thr_s};
      if (&{vlow_sh_q[1:0], trip_raw}) vlow_q <= 1'b1;
      else if (~|{vlow_sh_q[1:0], trip_raw}) vlow_q <= 1'b0;
      if (&{thr_sh_q[1:0], thr_s}) thr_q <= 1'b1;
      else if (~|{thr_sh_q[1:0], thr_s}) thr_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) thr_d1_q <= 1'b0;
    else thr_d1_q <= thr_q;
  end

  // ***********************************************
  // Open/close sequencing
  // ***********************************************
  // latch and compare
  logic [15:0] cmp_q;
  logic [1:0]  match_cnt_q;
  logic        open_q, seq_done;
  logic [7:0]  open_h_q, open_l_q;
  logic [15:0] key;
  assign key = {open_h_q, open_l_q};
  always_ff @(posedge clk) begin
    if (sys_rst) cmp_q <= 16'h0;
    else if (acs_fall) cmp_q <= a_s;
  end
  // three consecutive matches then enable high
  always_ff @(posedge clk) begin
    if (sys_rst || vlow_q) match_cnt_q <= 2'h0;
    else if (acs_fall) begin
      if (a_s != key) match_cnt_q <= 2'h0;
      else if (match_cnt_q != 2'(HMS_MATCHES)) match_cnt_q <= match_cnt_q + 2'h1;
    end else if (seq_done) match_cnt_q <= 2'h0;
  end
  assign seq_done = ce_rise && (match_cnt_q == 2'(HMS_MATCHES)) && (cmp_q == key);
  // auto-open on power failure when enabled
  always_ff @(posedge clk) begin
    if (sys_rst) open_q <= 1'b0;
    else if (vlow_q && !cfg_act_q[HMS_CFG_NOAUTO] && thr_q) open_q <= 1'b1;
    else if (seq_done) open_q <= ~open_q;
  end

  // ***********************************************
  // Window decode and internal SRAM
  // ***********************************************
  // window select
  logic in_win;
  assign in_win = cfg_act_q[HMS_CFG_LOWBLK] ? (a_s[15:11] == 5'h00) : (a_s[15:11] == 5'h1f);
  logic [HMS_AW-1:0] idx;
  assign idx = a_s[HMS_AW-1:0];
  logic [31:0] hold_cnt_q;
  logic        hold_q;
  logic acc_ok;
  assign acc_ok = open_q && in_win && !ce_s && !vlow_q && !hold_q;
  // memory with register bytes on top
  // Register bytes come up at defaults; a patterned close re-arms the AC bytes
  always_ff @(posedge clk) begin
    if (sys_rst || !def_s) begin
      mem[HMS_REG_BASE + 11'(HMS_IX_AC1)]   <= HMS_AC1_DEF;
      mem[HMS_REG_BASE + 11'h1]             <= HMS_AC2_DEF;
      mem[HMS_REG_BASE + 11'h2]             <= HMS_AC3_DEF;
      mem[HMS_REG_BASE + 11'h3]             <= HMS_AC4_DEF;
      mem[HMS_REG_BASE + 11'(HMS_IX_OPENL)] <= HMS_OPENL_DEF;
      mem[HMS_REG_BASE + 11'(HMS_IX_OPENH)] <= HMS_OPENH_DEF;
      mem[HMS_REG_BASE + 11'(HMS_IX_CFG)]   <= HMS_CFG_DEF;
      mem[HMS_REG_BASE + 11'(HMS_IX_SCR)]   <= HMS_SCR_DEF;
    end else if (seq_done && open_q && upd_ok) begin
      mem[HMS_REG_BASE + 11'(HMS_IX_AC1)] <= HMS_AC1_DEF;
      mem[HMS_REG_BASE + 11'h1]           <= HMS_AC2_DEF;
      mem[HMS_REG_BASE + 11'h2]           <= HMS_AC3_DEF;
      mem[HMS_REG_BASE + 11'h3]           <= HMS_AC4_DEF;
    end else if (acc_ok && !we_s) begin
      mem[idx] <= d_s_q;
    end
  end
  logic upd_ok;
  assign upd_ok = {mem[HMS_REG_BASE+3], mem[HMS_REG_BASE+2],
                   mem[HMS_REG_BASE+1], mem[HMS_REG_BASE]} == HMS_UPD_PAT;
  // apply config on close with pattern
  always_ff @(posedge clk) begin
    if (sys_rst || !def_s) begin
      cfg_act_q <= HMS_CFG_DEF;
      scr_act_q <= HMS_SCR_DEF;
      open_h_q  <= HMS_OPENH_DEF;
      open_l_q  <= HMS_OPENL_DEF;
    end else if (seq_done && open_q && upd_ok) begin
      cfg_act_q <= mem[HMS_REG_BASE + 11'(HMS_IX_CFG)];
      scr_act_q <= mem[HMS_REG_BASE + 11'(HMS_IX_SCR)];
      open_h_q  <= mem[HMS_REG_BASE + 11'(HMS_IX_OPENH)];
      open_l_q  <= mem[HMS_REG_BASE + 11'(HMS_IX_OPENL)];
    end
  end
  always_ff @(posedge clk) begin
    if (acc_ok && we_s && !oe_s) begin
      data_out  <= mem[idx];
      data_oe_n <= 1'b0;
    end else begin
      data_out  <= 8'h0;
      data_oe_n <= 1'b1;
    end
  end
  assign mem_open_out = open_q;

  // ***********************************************
  // Select hold-off and gated select
  // ***********************************************
  always_ff @(posedge clk) begin
    if (sys_rst || vlow_q) begin
      hold_cnt_q <= 32'h0;
      hold_q     <= 1'b1;
    end else if (tick && hold_q) begin
      if (hold_cnt_q >= 32'(HOLD_TICKS - 1)) hold_q <= 1'b0;
      hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) gated_select_out <= 1'b1;
    else if (hold_q || (vlow_q && ce_s) || (open_q && in_win)) gated_select_out <= 1'b1;
    else if (!vlow_q) gated_select_out <= ce_s;
  end

  // ***********************************************
  // Watchdog
  // ***********************************************
  logic [31:0] wd_cnt_q, wd_lim;
  logic        wd_to;
  always_comb begin
    unique case (scr_act_q[HMS_SCR_WDSEL +: 2])
      2'h0: wd_lim = 32'(WD0_TICKS);
      2'h1: wd_lim = 32'(WD1_TICKS);
      2'h2: wd_lim = 32'(WD2_TICKS);
      2'h3: wd_lim = 32'h0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst || wd_fall || seq_done || vlow_q || wd_lim == 32'h0 || wd_to) wd_cnt_q <= 32'h0;
    else if (tick) wd_cnt_q <= wd_cnt_q + 32'h1;
  end
  assign wd_to = (wd_lim != 32'h0) && (wd_cnt_q >= wd_lim);

  // ***********************************************
  // Reset and interrupt pulses
  // ***********************************************
  // interrupt pulse
  logic [15:0] irq_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst) irq_cnt_q <= 16'h0;
    else if ((thr_q && !thr_d1_q) || (wd_to && scr_act_q[HMS_SCR_WDIRQ]))
      irq_cnt_q <= 16'(HMS_IRQW_TICKS);
    else if (tick && irq_cnt_q != 16'h0) irq_cnt_q <= irq_cnt_q - 16'h1;
  end
  logic [31:0] rst_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || vlow_q || !def_s || (wd_to && !scr_act_q[HMS_SCR_WDIRQ]))
      rst_cnt_q <= 32'(RSTW_TICKS);
    else if (tick && rst_cnt_q != 32'h0) rst_cnt_q <= rst_cnt_q - 32'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_out   <= 1'b0;
      rst_out_n <= 1'b1;
      irq_out   <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      rst_out   <= cfg_act_q[HMS_CFG_RSTEN] && rst_cnt_q != 32'h0;
      rst_out_n <= !(cfg_act_q[HMS_CFG_RSTEN] && rst_cnt_q != 32'h0);
      irq_out   <= irq_cnt_q != 16'h0;
      irq_out_n <= irq_cnt_q == 16'h0;
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  property p_open_toggle;
    @(posedge clk) disable iff (sys_rst) seq_done |=> open_q != $past(open_q);
  endproperty
  a_open_toggle: assert property (p_open_toggle) else $error("open not toggled");
  property p_hide;
    @(posedge clk) disable iff (sys_rst) (open_q && in_win) |=> gated_select_out;
  endproperty
  a_hide: assert property (p_hide) else $error("select passed in window");
  property p_wp;
    @(posedge clk) disable iff (sys_rst) vlow_q |-> !acc_ok;
  endproperty
  a_wp: assert property (p_wp) else $error("access during low supply");
  property p_hold;
    @(posedge clk) disable iff (sys_rst) hold_q |=> gated_select_out;
  endproperty
  a_hold: assert property (p_hold) else $error("select during hold-off");
  property p_inhibit;
    @(posedge clk) disable iff (sys_rst) !cfg_act_q[HMS_CFG_RSTEN] |=> !rst_out && rst_out_n;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("reset not inhibited");
  property p_def;
    @(posedge clk) disable iff (sys_rst) !def_s |=> ##1 (cfg_act_q == HMS_CFG_DEF) && rst_out;
  endproperty
  a_def: assert property (p_def) else $error("default restore failed");
  property p_irq_pair;
    @(posedge clk) disable iff (sys_rst) irq_out == !irq_out_n;
  endproperty
  a_irq_pair: assert property (p_irq_pair) else $error("irq pair mismatch");
  property p_wd_restart;
    @(posedge clk) disable iff (sys_rst) (wd_fall || seq_done) |=> wd_cnt_q == 32'h0;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");
  c_open: cover property (@(posedge clk) disable iff (sys_rst) seq_done && !open_q);
  c_close: cover property (@(posedge clk) disable iff (sys_rst) seq_done && open_q && upd_ok);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq_out));
endmodule

// ### tb/hms_ext_sram.sv
/* External static RAM on the host bus, selected by the gated select.
   Assumes the bench drives the bus pins and the block the select. */
`timescale 1ns/1ps
module hms_ext_sram (
  // Bus side
  input  wire logic        clk,
  input  wire logic [15:0] addr_in,
  input  wire logic        select_n,
  input  wire logic        write_en_n,
  input  wire logic        out_en_n,
  input  wire logic [7:0]  data_in,
  // Read data
  output logic      [7:0]  data_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  always @(posedge clk) begin
    if (!select_n && !write_en_n) begin
      mem[addr_in] <= data_in;
    end
  end

  // Released bus toggles so stale data never passes as valid
  always @(posedge clk) begin
    if (!select_n && !out_en_n) begin
      last_q <= mem[addr_in];
    end else begin
      last_q <= ~last_q;
    end
  end

  assign data_out = last_q;
endmodule

// ### tb/tb_top.sv
/* Self-checking bench for hms_top beside an external RAM model.
   Assumes tick counts shortened through the top's parameters. */
`timescale 1ns/1ps
module tb_top;
  import hms_pkg::*;
  localparam int TK = HMS_TICK_CYC;
  logic        clk, sys_rst, addr_compare_strobe_n, chip_en_n, write_en_n;
  logic        out_en_n, wdog_strobe_n, default_restore_n, threshold_sense_in;
  logic        trip_hi_sense_in, trip_lo_sense_in, data_oe_n, gated_select_out;
  logic        rst_out, rst_out_n, irq_out, irq_out_n, mem_open_out, gs;
  logic [15:0] addr_in;
  logic [7:0]  data_in, data_out, ext_data, rd;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  hms_top #(.HOLD_TICKS(4), .RSTW_TICKS(4), .WD0_TICKS(4), .WD1_TICKS(6),
    .WD2_TICKS(8)) uut (.clk, .sys_rst, .addr_in, .addr_compare_strobe_n,
    .chip_en_n, .write_en_n, .out_en_n, .data_in, .data_out, .data_oe_n,
    .wdog_strobe_n, .default_restore_n, .threshold_sense_in, .trip_hi_sense_in,
    .trip_lo_sense_in, .gated_select_out, .rst_out, .rst_out_n, .irq_out,
    .irq_out_n, .mem_open_out);
  hms_ext_sram ext (.clk, .addr_in, .select_n(gated_select_out), .write_en_n,
    .out_en_n, .data_in, .data_out(ext_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Run is about 17 ticks; ceiling leaves margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      miscompares++;
      finish_test();
    end
  end

  // ********
  // Helpers
  // ********
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %b", $time, what, got);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h", $time, what, got);
    end
  endtask

  task automatic finish_test();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Address settles a cycle before the strobe falls
  task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    addr_in <= a;
    data_in <= wd;
    chip_en_n <= 1'b0;
    write_en_n <= ~wr;
    out_en_n <= wr;
    @(posedge clk);
    addr_compare_strobe_n <= 1'b0;
    wait_cyc(8);
    rd = data_oe_n ? ext_data : data_out;
    gs = gated_select_out;
    @(posedge clk);
    addr_compare_strobe_n <= 1'b1;
    chip_en_n <= 1'b1;
    write_en_n <= 1'b1;
    out_en_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic set_supply(input logic low);
    @(posedge clk);
    trip_hi_sense_in <= low;
    trip_lo_sense_in <= low;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_power_up();
    wait_cyc(20);
    chk_bit(rst_out, 1'b1, "reset while supply low");
    chk_bit(rst_out_n, 1'b0, "reset_n while supply low");
    set_supply(1'b0);
    addr_in <= 16'h1000;
    chip_en_n <= 1'b0;
    wait_cyc(5 * TK);
    chk_bit(rst_out, 1'b1, "reset pulse short");
    chk_bit(gated_select_out, 1'b1, "select in hold-off");
    wait_cyc(4 * TK);
    chk_bit(rst_out_n, 1'b1, "reset not ended");
    chk_bit(gated_select_out, 1'b0, "select not passed");
    @(posedge clk);
    chip_en_n <= 1'b1;
    wait_cyc(8);
    chk_bit(gated_select_out, 1'b1, "select not following");
  endtask

  task automatic t_open_seq();
    logic [15:0] seq [6] = '{16'h07ff, 16'h07ff, 16'h0123, 16'h07ff, 16'h07ff, 16'h07ff};
    cyc(16'hf900, 1'b1, 8'h33);
    chk_bit(gs, 1'b0, "closed window passes");
    for (int i = 0; i < 6; i++) begin
      cyc(seq[i], 1'b0, 8'h00);
      chk_bit(mem_open_out, i == 5, "open after matches");
    end
  endtask

  task automatic t_access();
    logic [15:0] ra [3] = '{16'hfff8, 16'hfffc, 16'hfffd};
    logic [7:0]  rv [3] = '{8'hc5, 8'hff, 8'h07};
    cyc(16'hf800, 1'b0, 8'h00);
    chk_bit(gs, 1'b1, "window select blocked");
    cyc(16'h1000, 1'b0, 8'h00);
    chk_bit(gs, 1'b0, "outside passes");
    for (int i = 0; i < 3; i++) begin
      cyc(ra[i], 1'b0, 8'h00);
      chk_byte(rd, rv[i], "register default");
    end
    cyc(16'hf900, 1'b1, 8'h5a);
    cyc(16'hf900, 1'b0, 8'h00);
    chk_byte(rd, 8'h5a, "hidden read back");
  endtask

  task automatic t_close();
    repeat (3) cyc(16'h07ff, 1'b0, 8'h00);
    chk_bit(mem_open_out, 1'b0, "closed");
    cyc(16'hf900, 1'b0, 8'h00);
    chk_byte(rd, 8'h33, "external after close");
    repeat (3) cyc(16'h07ff, 1'b0, 8'h00);
    cyc(16'hf900, 1'b0, 8'h00);
    chk_byte(rd, 8'h5a, "hidden kept");
  endtask

  task automatic t_restore();
    @(posedge clk);
    default_restore_n <= 1'b0;
    wait_cyc(20);
    chk_bit(rst_out, 1'b1, "restore forces reset");
    @(posedge clk);
    default_restore_n <= 1'b1;
    wait_cyc(TK);
    chk_bit(rst_out_n, 1'b0, "reset after restore");
  endtask

  task automatic t_irq();
    @(posedge clk);
    threshold_sense_in <= 1'b1;
    wait_cyc(TK);
    chk_bit(irq_out, 1'b0, "irq before three samples");
    wait_cyc(2 * TK + 50);
    chk_bit(irq_out, 1'b1, "irq");
    chk_bit(irq_out_n, 1'b0, "irq_n");
    @(posedge clk);
    threshold_sense_in <= 1'b0;
    wait_cyc(TK);
    chk_bit(irq_out, 1'b1, "irq pulse held");
    chk_bit(rst_out, 1'b0, "restore pulse ended");
  endtask

  task automatic t_supply_fail();
    @(posedge clk);
    addr_in <= 16'h1000;
    chip_en_n <= 1'b0;
    wait_cyc(10);
    chk_bit(gated_select_out, 1'b0, "select passes");
    set_supply(1'b1);
    wait_cyc(3 * TK + 50);
    // End the running cycle, then try a new one under low supply
    @(posedge clk);
    chip_en_n <= 1'b1;
    wait_cyc(8);
    @(posedge clk);
    chip_en_n <= 1'b0;
    wait_cyc(8);
    chk_bit(gated_select_out, 1'b1, "select forced off");
    chk_bit(rst_out, 1'b1, "reset on supply loss");
  endtask

  initial begin
    sys_rst = 1'b1;
    addr_in = 16'h0000;
    data_in = 8'h00;
    addr_compare_strobe_n = 1'b1;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    out_en_n = 1'b1;
    wdog_strobe_n = 1'b1;
    default_restore_n = 1'b1;
    threshold_sense_in = 1'b0;
    trip_hi_sense_in = 1'b1;
    trip_lo_sense_in = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_power_up();
    t_open_seq();
    t_access();
    t_close();
    t_restore();
    t_irq();
    t_supply_fail();
    finish_test();
  end
endmodule
